// File: src/mvcd_pkg.sv
// Constants, register map and types of the magnetic vector change detector
package mvcd_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_INT_SRC = 8'h5E;
	localparam logic [7:0] IDX_CFG = 8'h69;
	localparam logic [7:0] IDX_THS_HI = 8'h6A;
	localparam logic [7:0] IDX_THS_LO = 8'h6B;
	localparam logic [7:0] IDX_CNT = 8'h6C;
	localparam logic [7:0] IDX_INIT_XH = 8'h6D;
	localparam logic [7:0] IDX_INIT_XL = 8'h6E;
	localparam logic [7:0] IDX_INIT_YH = 8'h6F;
	localparam logic [7:0] IDX_INIT_YL = 8'h70;
	localparam logic [7:0] IDX_INIT_ZH = 8'h71;
	localparam logic [7:0] IDX_INIT_ZL = 8'h72;
	localparam logic [7:0] IDX_MODE = 8'h73;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_ELE = 6;
	localparam int CFG_INITM = 5;
	localparam int CFG_UPDM = 4;
	localparam int CFG_EN = 3;
	localparam int CFG_WAKE = 2;
	localparam int CFG_INT_EN = 1;
	localparam int CFG_ROUTE = 0;
	localparam logic [7:0] CFG_RW_MASK = 8'h7F;
	localparam int THS_HI_DBM = 7;
	localparam logic [7:0] THS_HI_MASK = 8'hFF;
	localparam int INT_SRC_VECM = 1;
	localparam int MODE_HYBRID = 0;
	localparam logic [7:0] MODE_RW_MASK = 8'h01;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [8:0] RST_DBC = 9'h000;
	localparam logic [31:0] RST_RDATA = 32'h00000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} mvcd_sample_t;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] ths_hi;
		logic [7:0] ths_lo;
		logic [7:0] cnt_val;
		logic [15:0] init_x;
		logic [15:0] init_y;
		logic [15:0] init_z;
		logic [7:0] mode;
		mvcd_sample_t ref_v;
		mvcd_sample_t last_v;
		logic [8:0] dbc;
		logic flag;
		logic half;
		logic [31:0] prdata;
	} mvcd_state_t;

endpackage

// File: src/mvcd_axis_sq.sv
// Squared difference of one axis against its reference component
`timescale 1ns/10ps
module mvcd_axis_sq
(
	input wire logic signed [15:0] sample_in,
	input wire logic signed [15:0] ref_in,
	output logic [31:0] sq_out
);

	logic signed [16:0] diff;
	logic [15:0] mag;

	always_comb
	begin
		diff = 17'({sample_in[15], sample_in}) - 17'({ref_in[15], ref_in});
		mag = diff[16] ? 16'(-diff) : diff[15:0];
		sq_out = 32'(mag) * 32'(mag);
	end

endmodule

// File: src/mvcd_top.sv
// Magnetic vector change detector with APB register access
// Function
// - Latched flag holds until source register read
// - Unlatched flag follows each sample's detection
// - Init select 0 loads current sample
// - Init select 1 loads programmed initial values
// - Update hold 0 replaces reference on event
// - Update hold 1 keeps reference on event
// - Both set: initial writes update live reference
// - Enable gates detection, rising loads reference
// - Wake include bit gates flag to auto-sleep
// - Interrupt enable gates the pin output
// - Route bit: 0 second pin, 1 first
// - Clear mode 0 decrements counter below threshold
// - Clear mode 1 zeroes counter below threshold
// - Threshold 15-bit, split high and low
// - Debounce length is count times sample period
// - Hybrid mode halves the debounce sample rate
// - Initial components are signed 16-bit byte pairs
// - Event when distance exceeds threshold past count
// - Event shown as own source register bit
`timescale 1ns/10ps
module mvcd_top
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mvcd_pkg::ADDR_W-1:0] paddr,
	input wire logic [mvcd_pkg::DATA_W-1:0] pwdata,
	output logic [mvcd_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sample_valid,
	input wire mvcd_pkg::mvcd_sample_t sample,
	output logic irq_pin_first,
	output logic irq_pin_second,
	output logic wake_flag
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	mvcd_pkg::mvcd_state_t s_r;
	mvcd_pkg::mvcd_state_t s_nxt;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic [7:0] idx;
	logic word_ok;
	logic map_hit;
	logic [7:0] rd_byte;
	logic setup_ph;
	logic access_ph;
	logic wr_ok;
	logic rd_ok;

	assign idx = paddr[9:2];
	assign word_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign wr_ok = access_ph && pwrite && map_hit;
	assign rd_ok = access_ph && !pwrite && map_hit;

	always_comb
	begin
		map_hit = word_ok;
		rd_byte = mvcd_pkg::RST_BYTE;
		unique case (idx)
			mvcd_pkg::IDX_INT_SRC:
			begin
				rd_byte[mvcd_pkg::INT_SRC_VECM] = s_r.flag;
			end
			mvcd_pkg::IDX_CFG:
			begin
				rd_byte = s_r.cfg & mvcd_pkg::CFG_RW_MASK;
			end
			mvcd_pkg::IDX_THS_HI:
			begin
				rd_byte = s_r.ths_hi;
			end
			mvcd_pkg::IDX_THS_LO:
			begin
				rd_byte = s_r.ths_lo;
			end
			mvcd_pkg::IDX_CNT:
			begin
				rd_byte = s_r.cnt_val;
			end
			mvcd_pkg::IDX_INIT_XH:
			begin
				rd_byte = s_r.init_x[15:8];
			end
			mvcd_pkg::IDX_INIT_XL:
			begin
				rd_byte = s_r.init_x[7:0];
			end
			mvcd_pkg::IDX_INIT_YH:
			begin
				rd_byte = s_r.init_y[15:8];
			end
			mvcd_pkg::IDX_INIT_YL:
			begin
				rd_byte = s_r.init_y[7:0];
			end
			mvcd_pkg::IDX_INIT_ZH:
			begin
				rd_byte = s_r.init_z[15:8];
			end
			mvcd_pkg::IDX_INIT_ZL:
			begin
				rd_byte = s_r.init_z[7:0];
			end
			mvcd_pkg::IDX_MODE:
			begin
				rd_byte = s_r.mode & mvcd_pkg::MODE_RW_MASK;
			end
			default:
			begin
				map_hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Distance against reference
	// ----------------------------------------------------------------
	logic [31:0] sq_x;
	logic [31:0] sq_y;
	logic [31:0] sq_z;
	logic [33:0] dist_sq;
	logic [14:0] ths;
	logic [29:0] ths_sq;
	logic above;

	mvcd_axis_sq u_sq_x
	(
		.sample_in(sample.x),
		.ref_in(s_r.ref_v.x),
		.sq_out(sq_x)
	);

	mvcd_axis_sq u_sq_y
	(
		.sample_in(sample.y),
		.ref_in(s_r.ref_v.y),
		.sq_out(sq_y)
	);

	mvcd_axis_sq u_sq_z
	(
		.sample_in(sample.z),
		.ref_in(s_r.ref_v.z),
		.sq_out(sq_z)
	);

	assign ths = {s_r.ths_hi[6:0], s_r.ths_lo};
	assign ths_sq = 30'(ths) * 30'(ths);
	assign dist_sq = {2'h0, sq_x} + {2'h0, sq_y} + {2'h0, sq_z};
	assign above = dist_sq > {4'h0, ths_sq};

	// ----------------------------------------------------------------
	// Debounce and event decision
	// ----------------------------------------------------------------
	logic en;
	logic latch_en;
	logic tick;
	logic [8:0] dbc_inc;
	logic fire;
	logic live_edit;
	logic init_wr;

	assign en = s_r.cfg[mvcd_pkg::CFG_EN];
	assign latch_en = s_r.cfg[mvcd_pkg::CFG_ELE];
	// In hybrid mode only every second sample counts
	assign tick = sample_valid && en
		&& (!s_r.mode[mvcd_pkg::MODE_HYBRID] || s_r.half);
	assign dbc_inc = s_r.dbc + 9'h001;
	assign fire = tick && above && (dbc_inc > {1'b0, s_r.cnt_val});
	assign live_edit = s_r.cfg[mvcd_pkg::CFG_INITM] && s_r.cfg[mvcd_pkg::CFG_UPDM] && en;
	assign init_wr = (idx >= mvcd_pkg::IDX_INIT_XH) && (idx <= mvcd_pkg::IDX_INIT_ZL);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;

		// Read data is captured in the setup cycle
		if (setup_ph)
		begin
			s_nxt.prdata = (!pwrite && map_hit) ? {24'h000000, rd_byte} : mvcd_pkg::RST_RDATA;
		end

		// Clear only what was reported, so a newer event survives
		if (rd_ok && (idx == mvcd_pkg::IDX_INT_SRC) && s_r.prdata[mvcd_pkg::INT_SRC_VECM])
		begin
			s_nxt.flag = 1'b0;
		end

		// Sample path
		if (sample_valid)
		begin
			s_nxt.last_v = sample;
			if (en && s_r.mode[mvcd_pkg::MODE_HYBRID])
			begin
				s_nxt.half = !s_r.half;
			end
		end

		if (tick)
		begin
			if (above)
			begin
				s_nxt.dbc = fire ? mvcd_pkg::RST_DBC : dbc_inc;
			end
			else if (s_r.ths_hi[mvcd_pkg::THS_HI_DBM])
			begin
				s_nxt.dbc = mvcd_pkg::RST_DBC;
			end
			else if (s_r.dbc != mvcd_pkg::RST_DBC)
			begin
				s_nxt.dbc = s_r.dbc - 9'h001;
			end
			if (latch_en)
			begin
				s_nxt.flag = s_nxt.flag || fire;
			end
			else
			begin
				s_nxt.flag = fire;
			end
			if (fire && !s_r.cfg[mvcd_pkg::CFG_UPDM])
			begin
				s_nxt.ref_v = sample;
			end
		end

		// Register writes
		if (wr_ok)
		begin
			unique case (idx)
				mvcd_pkg::IDX_CFG:
				begin
					s_nxt.cfg = pwdata[7:0] & mvcd_pkg::CFG_RW_MASK;
					if (!en && pwdata[mvcd_pkg::CFG_EN])
					begin
						s_nxt.dbc = mvcd_pkg::RST_DBC;
						s_nxt.half = 1'b0;
						if (pwdata[mvcd_pkg::CFG_INITM])
						begin
							s_nxt.ref_v.x = s_r.init_x;
							s_nxt.ref_v.y = s_r.init_y;
							s_nxt.ref_v.z = s_r.init_z;
						end
						else
						begin
							s_nxt.ref_v = s_r.last_v;
						end
					end
				end
				mvcd_pkg::IDX_THS_HI:
				begin
					s_nxt.ths_hi = pwdata[7:0] & mvcd_pkg::THS_HI_MASK;
				end
				mvcd_pkg::IDX_THS_LO:
				begin
					s_nxt.ths_lo = pwdata[7:0];
				end
				mvcd_pkg::IDX_CNT:
				begin
					s_nxt.cnt_val = pwdata[7:0];
				end
				mvcd_pkg::IDX_INIT_XH:
				begin
					s_nxt.init_x[15:8] = pwdata[7:0];
				end
				mvcd_pkg::IDX_INIT_XL:
				begin
					s_nxt.init_x[7:0] = pwdata[7:0];
				end
				mvcd_pkg::IDX_INIT_YH:
				begin
					s_nxt.init_y[15:8] = pwdata[7:0];
				end
				mvcd_pkg::IDX_INIT_YL:
				begin
					s_nxt.init_y[7:0] = pwdata[7:0];
				end
				mvcd_pkg::IDX_INIT_ZH:
				begin
					s_nxt.init_z[15:8] = pwdata[7:0];
				end
				mvcd_pkg::IDX_INIT_ZL:
				begin
					s_nxt.init_z[7:0] = pwdata[7:0];
				end
				mvcd_pkg::IDX_MODE:
				begin
					s_nxt.mode = pwdata[7:0] & mvcd_pkg::MODE_RW_MASK;
				end
				default:
				begin
					s_nxt.mode = s_nxt.mode;
				end
			endcase

			// Manual reference steering while running; events never move it here
			if (live_edit && init_wr)
			begin
				s_nxt.ref_v.x = s_nxt.init_x;
				s_nxt.ref_v.y = s_nxt.init_y;
				s_nxt.ref_v.z = s_nxt.init_z;
			end
		end

		// Disabled state follows the new config, so a stopping write acts at once
		if (!s_nxt.cfg[mvcd_pkg::CFG_EN])
		begin
			s_nxt.dbc = mvcd_pkg::RST_DBC;
			s_nxt.half = 1'b0;
			if (!s_nxt.cfg[mvcd_pkg::CFG_ELE])
			begin
				s_nxt.flag = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			s_r.cfg <= mvcd_pkg::RST_BYTE;
			s_r.ths_hi <= mvcd_pkg::RST_BYTE;
			s_r.ths_lo <= mvcd_pkg::RST_BYTE;
			s_r.cnt_val <= mvcd_pkg::RST_BYTE;
			s_r.init_x <= mvcd_pkg::RST_WORD;
			s_r.init_y <= mvcd_pkg::RST_WORD;
			s_r.init_z <= mvcd_pkg::RST_WORD;
			s_r.mode <= mvcd_pkg::RST_BYTE;
			s_r.ref_v <= '0;
			s_r.last_v <= '0;
			s_r.dbc <= mvcd_pkg::RST_DBC;
			s_r.flag <= 1'b0;
			s_r.half <= 1'b0;
			s_r.prdata <= mvcd_pkg::RST_RDATA;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = s_r.prdata;
	assign pready = 1'b1;
	assign pslverr = access_ph && !map_hit;
	assign irq_pin_first = s_r.flag && s_r.cfg[mvcd_pkg::CFG_INT_EN]
		&& s_r.cfg[mvcd_pkg::CFG_ROUTE];
	assign irq_pin_second = s_r.flag && s_r.cfg[mvcd_pkg::CFG_INT_EN]
		&& !s_r.cfg[mvcd_pkg::CFG_ROUTE];
	assign wake_flag = s_r.flag && s_r.cfg[mvcd_pkg::CFG_WAKE];

endmodule

// File: testbench/mvcd_props.sv
// Port checker of the vector change detector
`timescale 1ns/10ps
module mvcd_props
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mvcd_pkg::ADDR_W-1:0] paddr,
	input wire logic [mvcd_pkg::DATA_W-1:0] pwdata,
	input wire logic [mvcd_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sample_valid,
	input wire mvcd_pkg::mvcd_sample_t sample,
	input wire logic irq_pin_first,
	input wire logic irq_pin_second,
	input wire logic wake_flag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic cause;
	// Interrupt pins and wake flag may only move after a sample tick or a bus access
	assign cause = sample_valid || (psel && penable);
	sequence s_acc;
		psel && penable;
	endsequence
	AST_ONE_PIN: assert property (!(irq_pin_first && irq_pin_second))
		else $error("both interrupt pins active");
	AST_FIRST_CAUSE: assert property ($changed(irq_pin_first) |-> $past(cause))
		else $error("first pin moved without cause");
	AST_SECOND_CAUSE: assert property ($changed(irq_pin_second) |-> $past(cause))
		else $error("second pin moved without cause");
	AST_WAKE_CAUSE: assert property ($changed(wake_flag) |-> $past(cause))
		else $error("wake flag moved without cause");
	AST_RST_QUIET: assert property ($fell(srst) |-> !irq_pin_first && !irq_pin_second && !wake_flag)
		else $error("outputs active after reset");
	AST_RD_BYTE: assert property (s_acc ##0 !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("read data above low byte");
	AST_MISALIGN: assert property (s_acc ##0 (paddr[1:0] != 2'h0) |-> pslverr)
		else $error("misaligned access not refused");
	AST_ERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access phase");
	AST_READY: assert property (s_acc |-> pready)
		else $error("access phase without ready");
endmodule
bind mvcd_top mvcd_props chk_u (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sample_valid(sample_valid), .sample(sample),
	.irq_pin_first(irq_pin_first), .irq_pin_second(irq_pin_second), .wake_flag(wake_flag));

// File: testbench/mvcd_src_model.sv
// Magnetometer sample source model
`timescale 1ns/10ps
module mvcd_src_model
(
	input wire logic clk_sys,
	output logic sample_valid,
	output mvcd_pkg::mvcd_sample_t sample
);
	initial
	begin
		sample_valid = 1'b0;
		sample = '0;
	end
	task automatic push(input logic signed [15:0] x, input logic signed [15:0] y = 16'sd0,
		input logic signed [15:0] z = 16'sd0);
		@(posedge clk_sys);
		sample_valid <= 1'b1;
		sample <= {x, y, z};
		@(posedge clk_sys);
		sample_valid <= 1'b0;
		// Stale data is scrambled so nothing relies on it
		sample <= ~{x, y, z};
		@(posedge clk_sys);
	endtask
endmodule

// File: testbench/tb.sv
// Register and detection tests of the vector change detector
`timescale 1ns/10ps
module tb;
	logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, sample_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic irq_pin_first, irq_pin_second, wake_flag, last_err;
	mvcd_pkg::mvcd_sample_t sample;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	mvcd_top dut_u (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sample_valid), .sample(sample),
		.irq_pin_first(irq_pin_first), .irq_pin_second(irq_pin_second), .wake_flag(wake_flag));
	mvcd_src_model src_u (.clk_sys(clk_sys), .sample_valid(sample_valid), .sample(sample));
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t data %h exp %h", $time, got, exp);
		end
	endtask
	// Pins as {first, second, wake}, looked at once the edge has landed
	task automatic chkp(input logic [2:0] exp);
		#1;
		check_count++;
		if ({irq_pin_first, irq_pin_second, wake_flag} !== exp)
		begin
			miscompares++;
			$display("BAD %0t pins %b exp %b", $time, {irq_pin_first, irq_pin_second, wake_flag}, exp);
		end
	endtask
	task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
		apb_raw({2'h0, idx, 2'h0}, wr, d);
	endtask
	task automatic apb_raw(input logic [11:0] a, input logic wr, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial
	begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		for (int i = 'h69; i <= 'h73; i++)
		begin
			apb(i[7:0], 1'b0, 32'h0);
			chk(rdv, 32'h0);
			apb(i[7:0], 1'b1, 32'hFFFFFFA5);
			apb(i[7:0], 1'b0, 32'h0);
			chk(rdv, (i == 'h69) ? 32'h25 : ((i == 'h73) ? 32'h01 : 32'hA5));
		end
		apb(8'h40, 1'b0, 32'h0);
		chk({31'h0, last_err}, 32'h1);
		chk(rdv, 32'h0);
		apb_raw(12'h1A5, 1'b1, 32'h0000007F);
		chk({31'h0, last_err}, 32'h1);
		apb_raw(12'h5A4, 1'b1, 32'h0000007F);
		chk({31'h0, last_err}, 32'h1);
		apb_raw(12'h1A6, 1'b0, 32'h0);
		chk(rdv, 32'h0);
		apb(mvcd_pkg::IDX_CFG, 1'b0, 32'h0);
		chk({31'h0, last_err}, 32'h0);
		chk(rdv, 32'h25);
		apb(mvcd_pkg::IDX_MODE, 1'b1, 32'h0);
		apb(mvcd_pkg::IDX_THS_HI, 1'b1, 32'h0);
		apb(mvcd_pkg::IDX_THS_LO, 1'b1, 32'h0A);
		apb(mvcd_pkg::IDX_CNT, 1'b1, 32'h0);
		src_u.push(16'sd100);
		apb(mvcd_pkg::IDX_CFG, 1'b1, 32'h4B);
		src_u.push(16'sd105);
		chkp(3'b000);
		src_u.push(16'sd111);
		chkp(3'b100);
		src_u.push(16'sd112);
		chkp(3'b100);
		apb(mvcd_pkg::IDX_INT_SRC, 1'b0, 32'h0);
		chk(rdv, 32'h02);
		chkp(3'b000);
		src_u.push(16'sd115);
		chkp(3'b000);
		apb(mvcd_pkg::IDX_CFG, 1'b1, 32'h0);
		apb(mvcd_pkg::IDX_INIT_XH, 1'b1, 32'h0);
		apb(mvcd_pkg::IDX_INIT_XL, 1'b1, 32'h32);
		apb(mvcd_pkg::IDX_INIT_YH, 1'b1, 32'hFF);
		apb(mvcd_pkg::IDX_INIT_YL, 1'b1, 32'hF6);
		apb(mvcd_pkg::IDX_INIT_ZH, 1'b1, 32'h0);
		apb(mvcd_pkg::IDX_INIT_ZL, 1'b1, 32'h14);
		apb(mvcd_pkg::IDX_CFG, 1'b1, 32'h3E);
		src_u.push(16'sd55, -16'sd10, 16'sd20);
		chkp(3'b000);
		src_u.push(16'sd50, 16'sd10, 16'sd20);
		chkp(3'b011);
		src_u.push(16'sd50, 16'sd10, 16'sd20);
		chkp(3'b011);
		src_u.push(16'sd52, -16'sd10, 16'sd20);
		chkp(3'b000);
		apb(mvcd_pkg::IDX_INIT_XL, 1'b1, 32'h46);
		src_u.push(16'sd72, -16'sd10, 16'sd20);
		chkp(3'b000);
		src_u.push(16'sd70, -16'sd10, 16'sd31);
		chkp(3'b011);
		apb(mvcd_pkg::IDX_CNT, 1'b1, 32'h02);
		for (int m = 0; m < 2; m++)
		begin
			apb(mvcd_pkg::IDX_CFG, 1'b1, 32'h0);
			apb(mvcd_pkg::IDX_THS_HI, 1'b1, {24'h0, m[0], 7'h00});
			apb(mvcd_pkg::IDX_CFG, 1'b1, 32'h3B);
			src_u.push(16'sd90);
			src_u.push(16'sd90);
			chkp(3'b000);
			src_u.push(16'sd70, -16'sd10, 16'sd20);
			src_u.push(16'sd90);
			src_u.push(16'sd90);
			chkp(m ? 3'b000 : 3'b100);
			src_u.push(16'sd90);
			chkp(m ? 3'b100 : 3'b000);
		end
		apb(mvcd_pkg::IDX_CFG, 1'b1, 32'h0);
		apb(mvcd_pkg::IDX_CNT, 1'b1, 32'h0);
		apb(mvcd_pkg::IDX_MODE, 1'b1, 32'h01);
		apb(mvcd_pkg::IDX_CFG, 1'b1, 32'h3C);
		src_u.push(16'sd90);
		chkp(3'b000);
		src_u.push(16'sd90);
		chkp(3'b001);
		report_and_stop();
	end
endmodule
